// File: inc/itd_pkg.sv
// Package: opcode classes, timing figures and operand decode constants
package itd_pkg;

  localparam int unsigned CORE_CLK_HZ     = 10000000;
  localparam logic [7:0]  SFR_BASE        = 8'h80;
  localparam logic [7:0]  SPARE_OPCODE    = 8'hA5;
  localparam logic [7:0]  NOP_OPCODE      = 8'h00;
  localparam logic [15:0] CODE_SIZE_BYTES = 16'h2000;
  localparam logic [15:0] PAGE_MASK       = 16'hF800;
  localparam logic [4:0]  BANK_STRIDE     = 5'h08;
  localparam logic [3:0]  NIBBLE_MASK     = 4'hF;

  // Clock figures
  localparam logic [3:0] CLK_1 = 4'h1;
  localparam logic [3:0] CLK_2 = 4'h2;
  localparam logic [3:0] CLK_3 = 4'h3;
  localparam logic [3:0] CLK_4 = 4'h4;
  localparam logic [3:0] CLK_5 = 4'h5;
  localparam logic [3:0] CLK_8 = 4'h8;

  // Byte counts
  localparam logic [1:0] LEN_1 = 2'h1;
  localparam logic [1:0] LEN_2 = 2'h2;
  localparam logic [1:0] LEN_3 = 2'h3;

  typedef enum logic [3:0] {
    ITD_BR_NONE     = 4'h0,
    ITD_BR_REL      = 4'h1,
    ITD_BR_PAGE     = 4'h2,
    ITD_BR_FULL     = 4'h3,
    ITD_BR_INDIRECT = 4'h4,
    ITD_BR_RETURN   = 4'h5,
    ITD_BR_IRET     = 4'h6
  } itd_branch_e;

  typedef enum logic [1:0] {
    ITD_ST_IDLE = 2'b00,
    ITD_ST_EXEC = 2'b01,
    ITD_ST_DONE = 2'b11
  } itd_state_e;

endpackage

// File: verilog/itd_target_calc.sv
// Branch target arithmetic: relative, page, full and indirect targets
`timescale 1ns/1ps
`default_nettype none

module itd_target_calc (
  input  wire logic [15:0] next_pc,
  input  wire logic [7:0]  rel_offset,
  input  wire logic [10:0] page_target_field,
  input  wire logic [15:0] full_target_field,
  input  wire logic [15:0] data_pointer,
  input  wire logic [7:0]  acc,
  output logic      [15:0] rel_target,
  output logic      [15:0] page_target,
  output logic      [15:0] full_target,
  output logic      [15:0] indirect_target
);

  assign rel_target = 16'(next_pc + {{8{rel_offset[7]}}, rel_offset});

  assign page_target = (next_pc & itd_pkg::PAGE_MASK) | {5'h00, page_target_field};

  assign full_target = full_target_field & 16'(itd_pkg::CODE_SIZE_BYTES - 16'h0001);

  assign indirect_target = 16'(data_pointer + {8'h00, acc});

endmodule
`default_nettype wire

// File: verilog/itd_decoder.sv
// Instruction decoder: byte count, clock cost, operand addressing and branch targets
`timescale 1ns/1ps
`default_nettype none

module itd_decoder (
  input  wire logic        core_clk,
  input  wire logic        srst,
  input  wire logic        issue,
  input  wire logic [7:0]  opcode,
  input  wire logic [7:0]  operand1,
  input  wire logic [7:0]  operand2,
  input  wire logic [15:0] pc,
  input  wire logic [1:0]  bank_select,
  input  wire logic [15:0] data_pointer,
  input  wire logic [7:0]  acc,
  input  wire logic        carry,
  input  wire logic        bit_value,
  input  wire logic [7:0]  compare_lhs,
  input  wire logic [7:0]  indirect_byte,
  output logic             busy_ff,
  output logic             done_ff,
  output logic [1:0]       length_ff,
  output logic [3:0]       clocks_ff,
  output logic             taken_ff,
  output logic [15:0]      next_pc_ff,
  output logic             direct_is_sfr_ff,
  output logic [7:0]       direct_addr_ff,
  output logic [4:0]       bank_register_addr_ff,
  output logic [4:0]       indirect_pointer_register_ff,
  output logic             bit_clear_ff,
  output logic             data_pointer_inc_ff,
  output logic [7:0]       nibble_acc_ff,
  output logic [7:0]       nibble_mem_ff
);

  itd_pkg::itd_state_e state_ff;
  itd_pkg::itd_state_e nxt_state;
  logic [3:0]  cnt_ff;
  logic [7:0]  op;
  logic [1:0]  len;
  logic [3:0]  base_clk;
  logic        is_cond;
  logic        cond;
  logic        is_bit_clear;
  itd_pkg::itd_branch_e br;
  logic [15:0] next_seq;
  logic [7:0]  rel_byte;
  logic [15:0] rel_t;
  logic [15:0] page_t;
  logic [15:0] full_t;
  logic [15:0] ind_t;
  logic [15:0] tgt;
  logic [3:0]  total_clk;

  ////////////////////////////////////////////////////////////////////////////
  // Opcode classification

  assign op = (opcode == itd_pkg::SPARE_OPCODE) ? itd_pkg::NOP_OPCODE : opcode;

  always_comb begin
    len          = itd_pkg::LEN_1;
    base_clk     = itd_pkg::CLK_1;
    is_cond      = 1'b0;
    cond         = 1'b0;
    is_bit_clear = 1'b0;
    br           = itd_pkg::ITD_BR_NONE;
    rel_byte     = operand1;
    // every figure below is system clocks
    if (op[3:0] == 4'h1) begin
      // Bit 4 splits the page jump (clear) from the page call (set)
      // absolute jump and absolute call
      len      = itd_pkg::LEN_2;
      base_clk = itd_pkg::CLK_3;
      br       = itd_pkg::ITD_BR_PAGE;
    end else if (op[3] && op[7:4] inside {4'h7, 4'h8, 4'hA}) begin
      // Bank register moves carrying an immediate or direct byte
      len      = itd_pkg::LEN_2;
      base_clk = itd_pkg::CLK_2;
    end else if (op[3] && op[7:4] inside {4'h6, 4'hE, 4'hF}) begin
      // Bank register ALU/move group: one byte, one clock
      len      = itd_pkg::LEN_1;
      base_clk = itd_pkg::CLK_1;
    end else begin
      case (op)
        8'h00: base_clk = itd_pkg::CLK_1;
        8'h02, 8'h12: begin
          len      = itd_pkg::LEN_3;
          base_clk = itd_pkg::CLK_4;
          br       = itd_pkg::ITD_BR_FULL;
        end
        8'h22: begin
          base_clk = itd_pkg::CLK_5;
          br       = itd_pkg::ITD_BR_RETURN;
        end
        8'h32: begin
          base_clk = itd_pkg::CLK_5;
          br       = itd_pkg::ITD_BR_IRET;
        end
        8'h80: begin
          len      = itd_pkg::LEN_2;
          base_clk = itd_pkg::CLK_3;
          br       = itd_pkg::ITD_BR_REL;
        end
        8'h40, 8'h50, 8'h60, 8'h70: begin
          len      = itd_pkg::LEN_2;
          base_clk = itd_pkg::CLK_2;
          is_cond  = 1'b1;
          br       = itd_pkg::ITD_BR_REL;
          case (op[5:4])
            2'b00:   cond = carry;
            2'b01:   cond = !carry;
            2'b10:   cond = (acc == 8'h00);
            default: cond = (acc != 8'h00);
          endcase
        end
        // direct bit jumps, set-test variant clears
        8'h10, 8'h20, 8'h30: begin
          len          = itd_pkg::LEN_3;
          base_clk     = itd_pkg::CLK_3;
          is_cond      = 1'b1;
          br           = itd_pkg::ITD_BR_REL;
          rel_byte     = operand2;
          cond         = (op == 8'h30) ? !bit_value : bit_value;
          is_bit_clear = (op == 8'h10) && bit_value;
        end
        // compare jumps; indirect form one clock more
        8'hB4, 8'hB5, 8'hB6, 8'hB7, 8'hB8, 8'hB9, 8'hBA, 8'hBB, 8'hBC, 8'hBD, 8'hBE, 8'hBF: begin
          len      = itd_pkg::LEN_3;
          base_clk = (op == 8'hB6 || op == 8'hB7) ? itd_pkg::CLK_4 : itd_pkg::CLK_3;
          is_cond  = 1'b1;
          br       = itd_pkg::ITD_BR_REL;
          rel_byte = operand2;
          cond     = (compare_lhs != operand1);
        end
        // decrement jumps, direct then register form
        8'hD5: begin
          len      = itd_pkg::LEN_3;
          base_clk = itd_pkg::CLK_3;
          is_cond  = 1'b1;
          br       = itd_pkg::ITD_BR_REL;
          rel_byte = operand2;
          cond     = (compare_lhs != 8'h01);
        end
        8'hD8, 8'hD9, 8'hDA, 8'hDB, 8'hDC, 8'hDD, 8'hDE, 8'hDF: begin
          len      = itd_pkg::LEN_2;
          base_clk = itd_pkg::CLK_2;
          is_cond  = 1'b1;
          br       = itd_pkg::ITD_BR_REL;
          cond     = (compare_lhs != 8'h01);
        end
        8'h73: begin
          base_clk = itd_pkg::CLK_3;
          br       = itd_pkg::ITD_BR_INDIRECT;
        end
        8'h90: begin
          len      = itd_pkg::LEN_3;
          base_clk = itd_pkg::CLK_3;
        end
        8'h83, 8'h93: base_clk = itd_pkg::CLK_3;
        8'hE0, 8'hE2, 8'hE3, 8'hF0, 8'hF2, 8'hF3: base_clk = itd_pkg::CLK_3;
        8'hA3: base_clk = itd_pkg::CLK_1;
        8'hA4: base_clk = itd_pkg::CLK_4;
        8'h84: base_clk = itd_pkg::CLK_8;
        8'h43, 8'h53, 8'h63, 8'h75, 8'h85: begin
          len      = itd_pkg::LEN_3;
          base_clk = itd_pkg::CLK_3;
        end
        8'hD6, 8'hD7: base_clk = itd_pkg::CLK_2;
        // Two-byte, two-clock operations
        8'h05, 8'h15, 8'h24, 8'h25, 8'h34, 8'h35, 8'h42, 8'h44, 8'h45, 8'h52, 8'h54, 8'h55,
        8'h62, 8'h64, 8'h65, 8'h72, 8'h74, 8'h82, 8'h86, 8'h87, 8'h92, 8'h94, 8'h95, 8'hA0,
        8'hA2, 8'hA6, 8'hA7, 8'hB0, 8'hB2, 8'hC0, 8'hC2, 8'hC5, 8'hD0, 8'hD2, 8'hE5, 8'hF5,
        8'h76, 8'h77: begin
          len      = itd_pkg::LEN_2;
          base_clk = itd_pkg::CLK_2;
        end
        // Indirect-memory single byte operations
        8'h06, 8'h07, 8'h16, 8'h17, 8'h26, 8'h27, 8'h36, 8'h37, 8'h46, 8'h47, 8'h56, 8'h57,
        8'h66, 8'h67, 8'h96, 8'h97, 8'hC6, 8'hC7, 8'hE6, 8'hE7, 8'hF6, 8'hF7:
          base_clk = itd_pkg::CLK_2;
        default: base_clk = itd_pkg::CLK_1;
      endcase
    end
  end

  assign next_seq = 16'(pc + {14'h0000, len});

  itd_target_calc u_target (
    .next_pc           (next_seq),
    .rel_offset        (rel_byte),
    .page_target_field ({op[7:5], operand1}),
    .full_target_field ({operand1, operand2}),
    .data_pointer      (data_pointer),
    .acc               (acc),
    .rel_target        (rel_t),
    .page_target       (page_t),
    .full_target       (full_t),
    .indirect_target   (ind_t)
  );

  always_comb begin
    case (br)
      itd_pkg::ITD_BR_REL:      tgt = (is_cond && !cond) ? next_seq : rel_t;
      itd_pkg::ITD_BR_PAGE:     tgt = page_t;
      itd_pkg::ITD_BR_FULL:     tgt = full_t;
      itd_pkg::ITD_BR_INDIRECT: tgt = ind_t;
      default:                  tgt = next_seq;
    endcase
  end

  // taken conditional costs one extra clock
  assign total_clk = (is_cond && cond) ? 4'(base_clk + 4'h1) : base_clk;

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer: holds busy for the instruction's clock cost

  always_comb begin
    case (state_ff)
      itd_pkg::ITD_ST_IDLE: nxt_state = issue ? ((total_clk == 4'h1) ? itd_pkg::ITD_ST_DONE : itd_pkg::ITD_ST_EXEC)
                                              : itd_pkg::ITD_ST_IDLE;
      itd_pkg::ITD_ST_EXEC: nxt_state = (cnt_ff == 4'h2) ? itd_pkg::ITD_ST_DONE : itd_pkg::ITD_ST_EXEC;
      itd_pkg::ITD_ST_DONE: nxt_state = itd_pkg::ITD_ST_IDLE;
      default:              nxt_state = itd_pkg::ITD_ST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      state_ff <= itd_pkg::ITD_ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Issue is only taken from idle; requests while busy are dropped, not queued
  always_ff @(posedge core_clk) begin
    if (srst) begin
      cnt_ff <= 4'h0;
    end else if (state_ff == itd_pkg::ITD_ST_IDLE && issue) begin
      cnt_ff <= total_clk;
    end else if (cnt_ff != 4'h0) begin
      cnt_ff <= 4'(cnt_ff - 4'h1);
    end
  end

  // Busy follows the next state, so it falls on the edge that returns to idle
  always_ff @(posedge core_clk) begin
    if (srst) begin
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
    end else begin
      busy_ff <= (nxt_state != itd_pkg::ITD_ST_IDLE);
      done_ff <= (nxt_state == itd_pkg::ITD_ST_DONE);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Decode results, captured when an instruction is issued

  always_ff @(posedge core_clk) begin
    if (srst) begin
      length_ff  <= 2'h0;
      clocks_ff  <= 4'h0;
      taken_ff   <= 1'b0;
      next_pc_ff <= 16'h0000;
    end else if (state_ff == itd_pkg::ITD_ST_IDLE && issue) begin
      length_ff  <= len;
      clocks_ff  <= total_clk;
      taken_ff   <= (br != itd_pkg::ITD_BR_NONE) && (!is_cond || cond);
      next_pc_ff <= tgt;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      direct_is_sfr_ff             <= 1'b0;
      direct_addr_ff               <= 8'h00;
      bank_register_addr_ff        <= 5'h00;
      indirect_pointer_register_ff <= 5'h00;
      bit_clear_ff                 <= 1'b0;
      data_pointer_inc_ff          <= 1'b0;
    end else if (state_ff == itd_pkg::ITD_ST_IDLE && issue) begin
      direct_addr_ff               <= operand1;
      // upper half of direct space is SFR
      direct_is_sfr_ff             <= (operand1 >= itd_pkg::SFR_BASE);
      bank_register_addr_ff        <= 5'(bank_select * itd_pkg::BANK_STRIDE) | {2'b00, op[2:0]};
      // pointer is R0 or R1 of the bank
      indirect_pointer_register_ff <= 5'(bank_select * itd_pkg::BANK_STRIDE) | {4'h0, op[0]};
      bit_clear_ff                 <= is_bit_clear;
      data_pointer_inc_ff          <= (op == 8'hA3);
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      nibble_acc_ff <= 8'h00;
      nibble_mem_ff <= 8'h00;
    end else if (state_ff == itd_pkg::ITD_ST_IDLE && issue && (op == 8'hD6 || op == 8'hD7)) begin
      nibble_acc_ff <= {acc[7:4], indirect_byte[3:0] & itd_pkg::NIBBLE_MASK};
      nibble_mem_ff <= {indirect_byte[7:4], acc[3:0] & itd_pkg::NIBBLE_MASK};
    end
  end

endmodule
`default_nettype wire

// File: bench/itd_decoder_properties.sv
// Concurrent checks on the decoder's ports
`timescale 1ns/1ps
`default_nettype none
module itd_decoder_properties (
  input wire logic        core_clk,
  input wire logic        srst,
  input wire logic        issue,
  input wire logic [7:0]  opcode,
  input wire logic [7:0]  operand1,
  input wire logic [7:0]  operand2,
  input wire logic [15:0] pc,
  input wire logic        busy_ff,
  input wire logic        done_ff,
  input wire logic [1:0]  length_ff,
  input wire logic [3:0]  clocks_ff,
  input wire logic        taken_ff,
  input wire logic [15:0] next_pc_ff,
  input wire logic        direct_is_sfr_ff,
  input wire logic [7:0]  direct_addr_ff
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);
  logic [3:0]       run_cnt_ff;
  wire logic        go       = issue && !busy_ff;
  wire logic [15:0] seq_pc   = pc + 16'h2;
  wire logic [15:0] pg_tgt   = {seq_pc[15:11], opcode[7:5], operand1};
  wire logic [15:0] rel_tgt  = seq_pc + {{8{operand1[7]}}, operand1};
  wire logic [15:0] full_tgt = {operand1, operand2} & 16'h1FFF;
  ////////////////////////////////////////////////////////////////////////
  // Busy cycles before the final one; zero in the first busy cycle
  always_ff @(posedge core_clk) begin
    if (srst || !busy_ff || done_ff) begin
      run_cnt_ff <= 4'h0;
    end else begin
      run_cnt_ff <= run_cnt_ff + 4'h1;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  a_xdata_timing: assert property (go && opcode inside {8'hE0, 8'hE2, 8'hE3, 8'hF0, 8'hF2, 8'hF3}
    |=> length_ff == 2'h1 && clocks_ff == 4'h3) else $error("external move timing wrong");
  a_return_timing: assert property (go && opcode inside {8'h22, 8'h32}
    |=> length_ff == 2'h1 && clocks_ff == 4'h5) else $error("return timing wrong");
  a_long_branch: assert property (go && opcode inside {8'h12, 8'h02}
    |=> length_ff == 2'h3 && clocks_ff == 4'h4 && next_pc_ff == $past(full_tgt)) else $error("long branch wrong");
  a_page_branch: assert property (go && opcode[4:0] inside {5'h01, 5'h11}
    |=> length_ff == 2'h2 && clocks_ff == 4'h3 && next_pc_ff == $past(pg_tgt)) else $error("page branch wrong");
  a_spare_nop: assert property (go && opcode == itd_pkg::SPARE_OPCODE
    |=> length_ff == 2'h1 && clocks_ff == 4'h1 && done_ff) else $error("spare opcode not a no-op");
  a_cond_penalty: assert property (go && opcode inside {8'h40, 8'h50, 8'h60, 8'h70}
    |=> length_ff == 2'h2 && clocks_ff == (taken_ff ? 4'h3 : 4'h2)) else $error("conditional jump timing wrong");
  a_rel_target: assert property (go && opcode == 8'h80
    |=> taken_ff && next_pc_ff == $past(rel_tgt)) else $error("relative target wrong");
  a_busy_count: assert property (done_ff
    |-> busy_ff && run_cnt_ff + 4'h1 == clocks_ff) else $error("busy span differs from clock count");
  a_direct_space: assert property (go && opcode inside {8'h53, 8'h43, 8'h63}
    |=> direct_is_sfr_ff == $past(operand1[7]) && direct_addr_ff == $past(operand1)) else $error("direct decode wrong");
  c_taken_done: cover property (done_ff && taken_ff);
  c_five_clocks: cover property (done_ff && clocks_ff == 4'h5);
  c_long_issue: cover property (go && opcode == 8'h12);
endmodule
`default_nettype wire

// File: bench/cpu_instruction_timing_decode_tb.sv
// Self-checking bench for the instruction timing decoder
`timescale 1ns/1ps
`default_nettype none
module cpu_instruction_timing_decode_tb;
  logic        core_clk = 1'b0;
  logic        srst = 1'b1;
  logic        issue, carry, bit_value;
  logic [1:0]  bank_select;
  logic [7:0]  opcode, operand1, operand2, acc, compare_lhs, indirect_byte;
  logic [15:0] pc, data_pointer;
  logic        busy_ff, done_ff, taken_ff, direct_is_sfr_ff, bit_clear_ff, data_pointer_inc_ff;
  logic [1:0]  length_ff;
  logic [3:0]  clocks_ff;
  logic [15:0] next_pc_ff;
  logic [7:0]  direct_addr_ff, nibble_acc_ff, nibble_mem_ff;
  logic [4:0]  bank_register_addr_ff, indirect_pointer_register_ff;
  logic [1:0]  e_len;
  logic [3:0]  e_clk;
  logic        e_tk, e_cond, chk_npc;
  logic [15:0] e_npc;
  int          errors, n_checks, seed, cyc;
  logic [7:0]  ops [39] = '{8'h78, 8'hA8, 8'h00, 8'hA5, 8'hA3, 8'hE0, 8'hE2, 8'hF0, 8'hF3, 8'h93, 8'h83, 8'h73, 8'h22, 8'h32,
    8'h12, 8'h02, 8'h11, 8'hF1, 8'h01, 8'hE1, 8'h90, 8'h53, 8'h43, 8'h63, 8'hD6, 8'hD7, 8'h80, 8'h40, 8'h50,
    8'h60, 8'h70, 8'hDA, 8'h20, 8'h10, 8'h30, 8'hD5, 8'hB4, 8'hB9, 8'hB6};

  itd_decoder uut (.*);

  initial begin
    forever #50 core_clk = ~core_clk;
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test();
    $display("checks=%0d errors=%0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  function automatic void lc(input logic [1:0] l, input logic [3:0] c);
    e_len = l;
    e_clk = c;
  endfunction
  function automatic void br(input logic [1:0] l, input logic [3:0] c, input logic t);
    lc(l, c);
    e_cond = 1'b1;
    e_tk = t;
  endfunction
  // Expected length, clock cost and next fetch address from the live inputs
  function automatic void model(input logic [7:0] o);
    logic [7:0] rel;
    e_cond = 1'b0;
    e_tk = 1'b0;
    case (o)
      8'h00, 8'hA5, 8'hA3: lc(2'h1, 4'h1);
      8'hE0, 8'hE2, 8'hF0, 8'hF3, 8'h93, 8'h83, 8'h73: lc(2'h1, 4'h3);
      8'h22, 8'h32: lc(2'h1, 4'h5);
      8'h12, 8'h02: lc(2'h3, 4'h4);
      8'h11, 8'hF1, 8'h01, 8'hE1: lc(2'h2, 4'h3);
      8'h90, 8'h53, 8'h43, 8'h63: lc(2'h3, 4'h3);
      8'hD6, 8'hD7: lc(2'h1, 4'h2);
      8'h78, 8'hA8: lc(2'h2, 4'h2);
      8'h80: br(2'h2, 4'h2, 1'b1);
      8'h40: br(2'h2, 4'h2, carry);
      8'h50: br(2'h2, 4'h2, !carry);
      8'h60: br(2'h2, 4'h2, acc == 8'h00);
      8'h70: br(2'h2, 4'h2, acc != 8'h00);
      8'hDA: br(2'h2, 4'h2, compare_lhs != 8'h01);
      8'h20, 8'h10: br(2'h3, 4'h3, bit_value);
      8'h30: br(2'h3, 4'h3, !bit_value);
      8'hD5: br(2'h3, 4'h3, compare_lhs != 8'h01);
      8'hB4, 8'hB9: br(2'h3, 4'h3, compare_lhs != operand1);
      default: br(2'h3, 4'h4, compare_lhs != operand1);
    endcase
    rel = (e_len == 2'h3) ? operand2 : operand1;
    e_npc = pc + 16'(e_len);
    if (e_tk) begin
      e_clk = e_clk + 4'h1;
      e_npc = e_npc + {{8{rel[7]}}, rel};
    end
    if (o inside {8'h12, 8'h02}) e_npc = {operand1, operand2} & (itd_pkg::CODE_SIZE_BYTES - 16'h1);
    if (o[4:0] inside {5'h01, 5'h11}) e_npc = {e_npc[15:11], o[7:5], operand1};
    if (o == 8'h73) e_npc = data_pointer + 16'(acc);
    chk_npc = !(o inside {8'h22, 8'h32});
  endfunction
  // One instruction; junk requests are offered while busy and must be refused
  task automatic run(input logic [7:0] o);
    int n;
    @(posedge core_clk);
    #1;
    opcode = o;
    issue = 1'b1;
    model(o);
    @(posedge core_clk);
    #1;
    for (n = 1; n < 12; n++) begin
      issue = (done_ff !== 1'b1);
      opcode = ~o;
      carry = ~carry;
      if (done_ff === 1'b1) break;
      @(posedge core_clk);
      #1;
    end
    check(16'(n), 16'(e_clk));
    check(length_ff, e_len);
    check(clocks_ff, e_clk);
    if (e_cond) check(taken_ff, e_tk);
    if (chk_npc) check(next_pc_ff, e_npc);
    check(data_pointer_inc_ff, o == 8'hA3);
    check(bit_clear_ff, o == 8'h10 && bit_value);
    if (o inside {8'h53, 8'h43, 8'h63}) check({direct_is_sfr_ff, direct_addr_ff}, {operand1[7], operand1});
    if (o inside {8'hB9, 8'hDA, 8'h78, 8'hA8}) check(bank_register_addr_ff, {bank_select, o[2:0]});
    if (o inside {8'hB6, 8'hD6, 8'hD7, 8'hE2, 8'hF3}) check(indirect_pointer_register_ff, {bank_select, 2'h0, o[0]});
    if (o inside {8'hD6, 8'hD7}) check({nibble_acc_ff, nibble_mem_ff}, {acc[7:4], indirect_byte[3:0], indirect_byte[7:4], acc[3:0]});
    if (o inside {8'hD6, 8'hD7}) check({nibble_acc_ff[3:0], nibble_mem_ff[3:0]}, {indirect_byte[3:0], acc[3:0]});
  endtask
  ////////////////////////////////////////////////////////////////////////
  always @(posedge core_clk) begin
    cyc++;
    if (cyc > 4000) begin
      errors++;
      end_of_test();
    end
  end
  initial begin
    seed = 32'h2e52;
    {issue, opcode, operand1, operand2, pc, bank_select, data_pointer, acc} = '0;
    {carry, bit_value, compare_lhs, indirect_byte} = '0;
    repeat (2) @(posedge core_clk);
    #1;
    srst = 1'b0;
    for (int k = 0; k < 4; k++) begin
      foreach (ops[i]) begin
        {pc, operand1, operand2} = $random(seed);
        {data_pointer, acc, compare_lhs} = $random(seed);
        {indirect_byte, bank_select, carry, bit_value} = 12'($random(seed));
        // Page crossing and the extreme offsets
        if (k == 0) begin
          pc = 16'h07FE;
          operand1 = 8'h80;
          operand2 = 8'h7F;
        end
        // Untaken forms: equal compare, count reaching zero, zero accumulator
        if (k == 1) begin
          compare_lhs = (ops[i] inside {8'hD5, 8'hDA}) ? 8'h01 : operand1;
          acc = 8'h00;
        end
        run(ops[i]);
      end
    end
    end_of_test();
  end
endmodule
bind itd_decoder itd_decoder_properties chk (.*);
`default_nettype wire
